// File: rtl/agc_pkg.sv
// Behaviour
// RULE_01: Reference pin low below high selects serial.
// RULE_02: Reference pin low above high selects parallel.
// RULE_03: Parallel mode ignores the stored control word.
// RULE_04: Parallel gain code from three pins.
// RULE_05: Parallel bandwidth trim derived from gain code.
// RULE_06: Parallel power down follows select pin high.
// RULE_07: Fault detection disabled in parallel mode.
// RULE_08: Serial mode: control word governs all settings.
// RULE_09: Word bits 2..0 are gain code.
// RULE_10: Word bits 5..3 are bandwidth trim.
// RULE_11: Bits 7..6 input select, bit 8 swap.
// RULE_12: Bit 9 shutdown, bit 10 external filter.
// RULE_13: Bit 11 picks fault detection pin.
// RULE_14: Bits 14..12 fault current, bit 15 zero.
// RULE_15: Host loads the word right after power on.
// RULE_16: Select fall arms; data taken on clock rise.
// RULE_17: Select rise moves shift to holding register.
// RULE_18: Host keeps clock high at select edges.
// RULE_19: Shift register end drives serial out.
// RULE_20: Word shifted most significant bit first.
// RULE_21: Select high: ignore link, serial out undriven.
package agc_pkg;

  // ---------------------------------------------------------------
  // Control word layout
  // ---------------------------------------------------------------
  localparam int WORD_W       = 16;
  localparam int GAIN_LSB     = 0;
  localparam int TRIM_LSB     = 3;
  localparam int INSEL_LSB    = 6;
  localparam int SWAP_BIT     = 8;
  localparam int POWER_DOWN_BIT     = 9;
  localparam int EXTERNAL_CAP_SMOOTHING_EN_BIT     = 10;
  localparam int FPIN_BIT     = 11;
  localparam int FCUR_LSB     = 12;
  localparam int SPARE_BIT    = 15;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ---------------------------------------------------------------
  // Parallel trim derivation
  // ---------------------------------------------------------------
  localparam logic [2:0] TRIM_LOW   = 3'h0;
  localparam logic [2:0] TRIM_MID   = 3'h1;
  localparam logic [2:0] TRIM_HIGH  = 3'h2;
  localparam logic [2:0] TRIM_TOP   = 3'h3;
  localparam logic [2:0] TRIM_EXT   = 3'h4;

  typedef enum logic {AGC_SERIAL, AGC_PARALLEL} agc_mode_e;

endpackage : agc_pkg

// File: rtl/agc_sync.sv
module agc_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1;
  logic s2;
  logic s3;

  // ---------------------------------------------------------------
  // Three stage sampler, change counts when stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= 1'b1;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end

  assign rise = (s2 == s3) && s3 && !level;
  assign fall = (s2 == s3) && !s3 && level;

endmodule : agc_sync

// File: rtl/agc_top.sv
module agc_top
  import agc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ref_cmp_serial,
  input  wire logic        select_or_power_down_pin,
  input  wire logic        clock_or_gain_msb_pin,
  input  wire logic        din_or_gain_mid_pin,
  input  wire logic        dout_or_gain_lsb_pin_in,
  output logic             dout_or_gain_lsb_pin_out,
  output logic             dout_or_gain_lsb_pin_oe_n,
  output logic             serial_mode,
  output logic [2:0]       gain_code,
  output logic [2:0]       bandwidth_trim,
  output logic [1:0]       input_select,
  output logic             input_sign_swap,
  output logic             power_down,
  output logic             external_cap_smoothing_en,
  output logic             fault_pin_select,
  output logic [2:0]       fault_bias_level,
  output logic             fault_detect_en,
  output logic [15:0]      amp_control_word
);
  import agc_pkg::*;

  // ---------------------------------------------------------------
  // Pin sampling
  // ---------------------------------------------------------------
  logic mode_lvl;
  logic cs_lvl;
  logic cs_rise;
  logic cs_fall;
  logic sck_lvl;
  logic sck_rise;
  logic sdi_lvl;
  logic g0_lvl;

  agc_sync u_mode (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (ref_cmp_serial),
    .level    (mode_lvl),
    .rise     (),
    .fall     ()
  );

  agc_sync u_cs (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (select_or_power_down_pin),
    .level    (cs_lvl),
    .rise     (cs_rise),
    .fall     (cs_fall)
  );

  agc_sync u_sck (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (clock_or_gain_msb_pin),
    .level    (sck_lvl),
    .rise     (sck_rise),
    .fall     ()
  );

  agc_sync u_sdi (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (din_or_gain_mid_pin),
    .level    (sdi_lvl),
    .rise     (),
    .fall     ()
  );

  agc_sync u_g0 (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (dout_or_gain_lsb_pin_in),
    .level    (g0_lvl),
    .rise     (),
    .fall     ()
  );

  agc_mode_e mode;
  assign mode = mode_lvl ? AGC_SERIAL : AGC_PARALLEL;  // see RULE_01 see RULE_02

  // ---------------------------------------------------------------
  // Shift register and holding register
  // ---------------------------------------------------------------
  logic [15:0] shift_reg;
  logic        armed;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (mode != AGC_SERIAL) begin
      armed <= 1'b0;
    end else if (cs_fall) begin
      armed <= 1'b1;  // see RULE_16
    end else if (cs_rise) begin
      armed <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= WORD_RESET;
    end else if (armed && !cs_lvl && sck_rise) begin
      shift_reg <= {shift_reg[14:0], sdi_lvl};  // see RULE_16 see RULE_20 see RULE_21
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_control_word <= WORD_RESET;
    end else if (armed && cs_rise) begin
      amp_control_word <= shift_reg;  // see RULE_17
    end
  end

  // ---------------------------------------------------------------
  // Serial out, driven only while selected
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_or_gain_lsb_pin_out  <= 1'b0;
      dout_or_gain_lsb_pin_oe_n <= 1'b1;
    end else begin
      dout_or_gain_lsb_pin_out  <= shift_reg[WORD_W-1];  // see RULE_19
      dout_or_gain_lsb_pin_oe_n <= !(mode == AGC_SERIAL && !cs_lvl);  // see RULE_21
    end
  end

  // ---------------------------------------------------------------
  // Parallel trim derivation
  // ---------------------------------------------------------------
  logic [2:0] par_gain;
  logic [2:0] par_trim;
  assign par_gain = {sck_lvl, sdi_lvl, g0_lvl};  // see RULE_04

  always_comb begin
    unique case (par_gain)
      3'h0, 3'h1: par_trim = TRIM_LOW;  // see RULE_05
      3'h2:       par_trim = TRIM_MID;
      3'h3, 3'h4: par_trim = TRIM_HIGH;
      3'h5, 3'h6: par_trim = TRIM_TOP;
      3'h7:       par_trim = TRIM_EXT;
    endcase
  end

  // ---------------------------------------------------------------
  // Applied settings
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_mode               <= 1'b1;
      gain_code                 <= 3'h0;
      bandwidth_trim            <= 3'h0;
      input_select              <= 2'h0;
      input_sign_swap           <= 1'b0;
      power_down                <= 1'b0;
      external_cap_smoothing_en <= 1'b0;
      fault_pin_select          <= 1'b0;
      fault_bias_level          <= 3'h0;
      fault_detect_en           <= 1'b0;
    end else if (mode == AGC_PARALLEL) begin
      serial_mode               <= 1'b0;  // see RULE_03
      gain_code                 <= par_gain;  // see RULE_04
      bandwidth_trim            <= par_trim;  // see RULE_05
      input_select              <= 2'h0;
      input_sign_swap           <= 1'b0;
      power_down                <= cs_lvl;  // see RULE_06
      external_cap_smoothing_en <= 1'b0;
      fault_pin_select          <= 1'b0;
      fault_bias_level          <= 3'h0;
      fault_detect_en           <= 1'b0;  // see RULE_07
    end else begin
      serial_mode               <= 1'b1;  // see RULE_08
      gain_code                 <= amp_control_word[GAIN_LSB +: 3];  // see RULE_09
      bandwidth_trim            <= amp_control_word[TRIM_LSB +: 3];  // see RULE_10
      input_select              <= amp_control_word[INSEL_LSB +: 2];  // see RULE_11
      input_sign_swap           <= amp_control_word[SWAP_BIT];  // see RULE_11
      power_down                <= amp_control_word[POWER_DOWN_BIT];  // see RULE_12
      external_cap_smoothing_en <= amp_control_word[EXTERNAL_CAP_SMOOTHING_EN_BIT];  // see RULE_12
      fault_pin_select          <= amp_control_word[FPIN_BIT];  // see RULE_13
      fault_bias_level          <= amp_control_word[FCUR_LSB +: 3];  // see RULE_14
      fault_detect_en           <= 1'b1;
    end
  end

endmodule : agc_top

// File: testbench/agc_asserts.sv
module agc_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ref_cmp_serial,
  input wire logic        select_or_power_down_pin,
  input wire logic        dout_or_gain_lsb_pin_oe_n,
  input wire logic        serial_mode,
  input wire logic [2:0]  gain_code,
  input wire logic [2:0]  bandwidth_trim,
  input wire logic        power_down,
  input wire logic        fault_detect_en,
  input wire logic [15:0] amp_control_word
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // Mode and field checks
  // ---------------------------------------------------------------
  a_trim_derive: assert property (!serial_mode && $past(!serial_mode) |->
    bandwidth_trim == (gain_code == 3'h7 ? 3'h4 : gain_code > 3'h4 ? 3'h3 :
    gain_code > 3'h2 ? 3'h2 : gain_code == 3'h2 ? 3'h1 : 3'h0)) else $error("trim");
  a_fault_off: assert property (!serial_mode && $past(!serial_mode) |-> !fault_detect_en)
    else $error("fault detect on in parallel");
  a_par_power_down: assert property ((!ref_cmp_serial && $stable(select_or_power_down_pin))[*6]
    |-> power_down == select_or_power_down_pin) else $error("parallel power down");
  a_gain_field: assert property (serial_mode && $past(serial_mode) && $past(serial_mode, 2)
    |-> gain_code == $past(amp_control_word[2:0])) else $error("gain field");
  a_trim_field: assert property (serial_mode && $past(serial_mode) && $past(serial_mode, 2)
    |-> bandwidth_trim == $past(amp_control_word[5:3])) else $error("trim field");
  a_power_down_field: assert property (serial_mode && $past(serial_mode) && $past(serial_mode, 2)
    |-> power_down == $past(amp_control_word[9])) else $error("shutdown field");
  a_word_hold: assert property ($changed(amp_control_word)
    |-> serial_mode && select_or_power_down_pin) else $error("word moved");
  a_out_idle: assert property ((select_or_power_down_pin || !ref_cmp_serial)[*6]
    |-> dout_or_gain_lsb_pin_oe_n) else $error("serial out driven");
  a_out_drive: assert property ((!select_or_power_down_pin && ref_cmp_serial)[*6]
    |-> !dout_or_gain_lsb_pin_oe_n) else $error("serial out not driven");
endmodule : agc_asserts

// File: testbench/agc_host.sv
module agc_host (
  output logic     cs_n,
  output logic     sck,
  output logic     serial_in,
  output logic     g0,
  input wire logic serial_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rx;
  initial begin
    {cs_n, sck, serial_in, g0, rx} = {4'b1100, 32'h0};
  end
  // Clock high at both select edges, MSB first
  task automatic send(input logic [31:0] d);
    cs_n = 0; #125;
    for (int i = 31; i >= 0; i--) begin
      sck = 0; serial_in = d[i]; #62.5;
      sck = 1; rx = {rx[30:0], serial_out}; #62.5;
    end
    #62.5 cs_n = 1; serial_in = ~serial_in; #250;
  endtask : send
  task automatic noise();
    repeat (4) begin
      sck = 0; serial_in = ~serial_in; #62.5; sck = 1; #62.5;
    end
  endtask : noise
  task automatic par(input logic [3:0] v);
    {cs_n, sck, serial_in, g0} = v;
  endtask : par
endmodule : agc_host

// File: testbench/agc_top_tb_top.sv
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t value mismatch", $time); end end
module agc_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, ref_cmp_serial, select_or_power_down_pin, clock_or_gain_msb_pin, g0, pd;
  logic din_or_gain_mid_pin, dout_or_gain_lsb_pin_in, dout_or_gain_lsb_pin_out;
  logic dout_or_gain_lsb_pin_oe_n, serial_mode, input_sign_swap, power_down;
  logic external_cap_smoothing_en, fault_pin_select, fault_detect_en;
  logic [2:0]  gain_code, bandwidth_trim, fault_bias_level;
  logic [1:0]  input_select;
  logic [15:0] amp_control_word, last, w, x, prev;
  logic [15:0] expq [$];
  logic [2:0]  trim_tab [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4};
  int          bad_count = 0, check_count = 0, seed = 55;
  assign dout_or_gain_lsb_pin_in = !dout_or_gain_lsb_pin_oe_n ? dout_or_gain_lsb_pin_out :
                                   ref_cmp_serial ? !dout_or_gain_lsb_pin_out : g0;
  agc_top dut (.*);
  agc_host host (.cs_n(select_or_power_down_pin), .sck(clock_or_gain_msb_pin),
    .serial_in(din_or_gain_mid_pin), .g0(g0), .serial_out(dout_or_gain_lsb_pin_in));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Watcher takes the oldest expected word on every word change
  initial last = 16'h0000;
  always @(posedge clk) if (rst_n === 1'b1 && amp_control_word !== last) begin
    last = amp_control_word;
    `CHK(expq.size() > 0, 1'b1)
    if (expq.size() > 0) `CHK(amp_control_word, expq.pop_front())
  end
  task automatic serial_round(input int n);
    for (int k = 0; k < n; k++) begin
      w = 16'($random(seed)) & 16'h7fff;
      if (w == prev) w ^= 16'h0001;
      x = 16'($random(seed));
      expq.push_back(w);
      host.noise();
      @(posedge clk) #1 host.send({x, w});
      `CHK(host.rx, {prev, x})
      `CHK({fault_detect_en, serial_mode, fault_bias_level, fault_pin_select,
        external_cap_smoothing_en, power_down, input_sign_swap, input_select,
        bandwidth_trim, gain_code}, {2'b11, w[14:0]})
      prev = w;
    end
  endtask : serial_round
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    #300us bad_count++;
    print_verdict();
  end
  initial begin
    {rst_n, ref_cmp_serial, prev} = {2'b01, 16'h0000};
    repeat (12) @(posedge clk);
    #1 rst_n = 1;
    repeat (4) @(posedge clk);
    #1 `CHK({serial_mode, dout_or_gain_lsb_pin_oe_n, amp_control_word}, 18'h30000)
    serial_round(4);
    @(posedge clk) #1 ref_cmp_serial = 0;
    for (int g = 0; g < 8; g++) begin
      pd = 1'($random(seed));
      @(posedge clk) #1 host.par({pd, 3'(g)});
      #100;
      `CHK(gain_code, 3'(g))
      `CHK(bandwidth_trim, trim_tab[g])
      `CHK(power_down, pd)
      `CHK({fault_detect_en, serial_mode, amp_control_word}, {2'b00, prev})
      `CHK({input_select, input_sign_swap, external_cap_smoothing_en, fault_pin_select,
        fault_bias_level}, 8'h00)
    end
    host.par(4'b1100);
    ref_cmp_serial = 1;
    #100;
    `CHK(serial_mode, 1'b1)
    serial_round(2);
    `CHK(expq.size() == 0, 1'b1)
    print_verdict();
  end
endmodule : agc_top_tb_top
bind agc_top agc_asserts u_chk (.*);
